/* hdl/ptp_cfg_defines.svh */
// register offsets, field positions and reset values of the page-6 bank
`ifndef PTP_CFG_DEFINES_SVH
`define PTP_CFG_DEFINES_SVH
`define PAGE_CFG          3'h6
`define OFF_CLK_OUT_CTRL  5'h14
`define OFF_HDR_WORD      5'h15
`define OFF_SA_HIGH       5'h16
`define OFF_SA_LOW        5'h17
`define COC_EN_BIT        15
`define COC_SEL_BIT       14
`define COC_FAST_BIT      13
`define COC_DIV_MSB       7
`define COC_RSVD_MASK     16'he0ff
`define COC_RESET         16'h800a
`define CFG_RESET         16'h0000
`define DIV_MIN_RUN       8'h02
`define COC_DIV_RESET     8'h0a
`define HDR_RSVD_LSB      12
`define HDR_VER_LSB       8
`define HDR_TRANS_LSB     4
`define HDR_MSG_LSB       0
`define BYTE_LO_LSB       0
`define BYTE_HI_LSB       8
`endif

/* hdl/ptp_cfg_pkg.sv */
// types shared by the clock output configuration bank
package ptp_cfg_pkg;
	typedef struct packed {
		logic       wr;
		logic [2:0] page;
		logic [4:0] addr;
		logic [15:0] wdata;
	} reg_req_s;
	typedef struct packed {
		logic [15:0] header_word;
		logic [31:0] source_addr;
	} status_frame_cfg_s;
endpackage

/* hdl/sync_clock_divider.sv */
// glitch-free divide-by-n of the selected root clock enable
`timescale 1ns/1ps
`default_nettype none
`include "ptp_cfg_defines.svh"
module sync_clock_divider #(
	parameter int DIV_W = 8
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             root_tick,
	input  wire logic [DIV_W-1:0] divider,
	output logic                  clk_div
);
	logic [DIV_W-1:0] cnt_ff;
	logic [DIV_W-1:0] div_ff;
	logic             out_ff;
	logic             run;
	logic             wrap;
	logic [DIV_W-1:0] half;

	assign run  = (div_ff >= DIV_W'(`DIV_MIN_RUN));
	assign wrap = (cnt_ff >= div_ff - DIV_W'(1));
	assign half = div_ff >> 1;
	assign clk_div = out_ff;

	// new divider is loaded only at period end or on every tick while stopped, so no runt pulse
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_ff <= '0;
			div_ff <= DIV_W'(`COC_DIV_RESET);
			out_ff <= 1'b0;
		end else if (root_tick) begin
			if (!run || wrap) begin
				cnt_ff <= '0;
				div_ff <= divider;
				out_ff <= (divider >= DIV_W'(`DIV_MIN_RUN));
			end else begin
				cnt_ff <= cnt_ff + DIV_W'(1);
				if (cnt_ff + DIV_W'(1) == half)
					out_ff <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* hdl/ptp_clkout_status_frame_cfg.sv */
// page-6 clock output control and status frame header registers
`timescale 1ns/1ps
`default_nettype none
`include "ptp_cfg_defines.svh"
module ptp_clkout_status_frame_cfg
	import ptp_cfg_pkg::*;
#(
	parameter int DIV_W = 8
) (
	input  wire logic                           clk,
	input  wire logic                           rstn,
	input  wire ptp_cfg_pkg::reg_req_s          req,
	input  wire logic                           pgm_tick,
	input  wire logic                           fco_tick,
	output logic [15:0]                         rdata,
	output logic                                sync_clock_out,
	output logic                                clock_pad_fast_edge,
	output ptp_cfg_pkg::status_frame_cfg_s      frame_cfg
);
	import ptp_cfg_pkg::*;

	////////////////////////////////////////////////////////////////////
	logic [15:0] coc_ff;
	logic [15:0] hdr_ff;
	logic [15:0] sa_hi_ff;
	logic [15:0] sa_lo_ff;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	logic        out_ff;
	logic        fast_ff;
	logic        sel_ff;
	logic        sel_tick_ff;
	status_frame_cfg_s frame_ff;
	logic        on_page;
	logic        wr_coc;
	logic        wr_hdr;
	logic        wr_sa_hi;
	logic        wr_sa_lo;
	logic        root_tick;
	logic        div_clk;

	// named fields of the clock control word
	logic        sync_clock_out_enable;
	logic        sync_clock_root_select;
	logic        fast_edge_bit;
	logic [7:0]  divider_value;

	// named fields of the status frame header word
	logic [3:0]  header_reserved_nibble;
	logic [3:0]  protocol_version_field;
	logic [3:0]  transport_kind_field;
	logic [3:0]  message_kind_field;

	// named bytes of the status frame source address
	logic [7:0]  source_addr_first_byte;
	logic [7:0]  source_addr_second_byte;
	logic [7:0]  source_addr_third_byte;
	logic [7:0]  source_addr_fourth_byte;

	////////////////////////////////////////////////////////////////////
	// one register of page six addressed; shared by write and read decode
	function automatic logic reg_hit(
		input reg_req_s   r,
		input logic [4:0] off
	);
		return (r.page == `PAGE_CFG) && (r.addr == off);
	endfunction

	// address decode, only page six is answered
	assign on_page  = (req.page == `PAGE_CFG);
	assign wr_coc   = req.wr && reg_hit(req, `OFF_CLK_OUT_CTRL);
	assign wr_hdr   = req.wr && reg_hit(req, `OFF_HDR_WORD);
	assign wr_sa_hi = req.wr && reg_hit(req, `OFF_SA_HIGH);
	assign wr_sa_lo = req.wr && reg_hit(req, `OFF_SA_LOW);

	// read mux; unmapped or other page reads zero
	// a miss reads zero rather than holding old data, so a stale page
	// select never leaks another register's contents
	assign nxt_rdata = !on_page ? 16'h0000 :
		reg_hit(req, `OFF_CLK_OUT_CTRL) ? coc_ff :
		reg_hit(req, `OFF_HDR_WORD)     ? hdr_ff :
		reg_hit(req, `OFF_SA_HIGH)      ? sa_hi_ff :
		reg_hit(req, `OFF_SA_LOW)       ? sa_lo_ff : 16'h0000;

	////////////////////////////////////////////////////////////////////
	// field split of the clock control word
	assign sync_clock_out_enable  = coc_ff[`COC_EN_BIT];
	assign sync_clock_root_select = coc_ff[`COC_SEL_BIT];
	assign fast_edge_bit          = coc_ff[`COC_FAST_BIT];
	assign divider_value          = coc_ff[`COC_DIV_MSB:0];

	// field split of the header word; reserved nibble is stored as written
	assign header_reserved_nibble = hdr_ff[`HDR_RSVD_LSB +: 4];
	assign protocol_version_field = hdr_ff[`HDR_VER_LSB +: 4];
	assign transport_kind_field   = hdr_ff[`HDR_TRANS_LSB +: 4];
	assign message_kind_field     = hdr_ff[`HDR_MSG_LSB +: 4];

	// address bytes; the low byte of each register is sent first
	assign source_addr_first_byte  = sa_hi_ff[`BYTE_LO_LSB +: 8];
	assign source_addr_second_byte = sa_hi_ff[`BYTE_HI_LSB +: 8];
	assign source_addr_third_byte  = sa_lo_ff[`BYTE_LO_LSB +: 8];
	assign source_addr_fourth_byte = sa_lo_ff[`BYTE_HI_LSB +: 8];

	////////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge clk) begin
		if (!rstn) begin
			coc_ff   <= `COC_RESET;
			hdr_ff   <= `CFG_RESET;
			sa_hi_ff <= `CFG_RESET;
			sa_lo_ff <= `CFG_RESET;
		end else begin
			if (wr_coc)
				coc_ff <= req.wdata & `COC_RSVD_MASK;
			if (wr_hdr)
				hdr_ff <= req.wdata;
			if (wr_sa_hi)
				sa_hi_ff <= req.wdata;
			if (wr_sa_lo)
				sa_lo_ff <= req.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			rdata_ff <= 16'h0000;
		else
			rdata_ff <= nxt_rdata;
	end
	assign rdata = rdata_ff;

	////////////////////////////////////////////////////////////////////
	// source switch applied between ticks, so no extra edge is made
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sel_ff      <= 1'b0;
			sel_tick_ff <= 1'b0;
		end else begin
			sel_ff      <= sync_clock_root_select;
			sel_tick_ff <= sel_ff ? pgm_tick : fco_tick;
		end
	end
	assign root_tick = sel_tick_ff;

	sync_clock_divider #(
		.DIV_W(DIV_W)
	) u_div (
		.clk      (clk),
		.rstn     (rstn),
		.root_tick(root_tick),
		.divider  (divider_value),
		.clk_div  (div_clk)
	);

	// output gate and pad control, all flopped
	always_ff @(posedge clk) begin
		if (!rstn) begin
			out_ff  <= 1'b0;
			fast_ff <= 1'b0;
		end else begin
			out_ff  <= sync_clock_out_enable & div_clk;
			fast_ff <= fast_edge_bit;
		end
	end
	assign sync_clock_out      = out_ff;
	assign clock_pad_fast_edge = fast_ff;

	////////////////////////////////////////////////////////////////////
	// header word and source address handed to frame builder
	always_ff @(posedge clk) begin
		if (!rstn)
			frame_ff <= '0;
		else begin
			frame_ff.header_word <= {header_reserved_nibble,
				protocol_version_field, transport_kind_field,
				message_kind_field};
			frame_ff.source_addr <= {source_addr_first_byte,
				source_addr_second_byte, source_addr_third_byte,
				source_addr_fourth_byte};
		end
	end
	assign frame_cfg = frame_ff;
endmodule
`default_nettype wire

/* verification/ptp_cfg_properties.sv */
// checker on the page-6 bank ports
`timescale 1ns/1ps
`default_nettype none
module ptp_cfg_properties
	import ptp_cfg_pkg::*;
(
	input wire logic                      clk,
	input wire logic                      rstn,
	input wire ptp_cfg_pkg::reg_req_s     req,
	input wire logic [15:0]               rdata,
	input wire logic                      sync_clock_out,
	input wire logic                      clock_pad_fast_edge,
	input wire ptp_cfg_pkg::status_frame_cfg_s frame_cfg
);
	// mapped page-6 writes by offset
	wire pg = req.page == 3'h6;
	wire w4 = req.wr && pg && req.addr == 5'h14;
	wire w5 = req.wr && pg && req.addr == 5'h15;
	wire w6 = req.wr && pg && req.addr == 5'h16;
	wire w7 = req.wr && pg && req.addr == 5'h17;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_off_page_zero: assert property (!pg |=> rdata == 16'h0)
		else $error("off-page read not zero");
	a_coc_read_back: assert property (w4 ##1 (pg && !req.wr
		&& req.addr == 5'h14) |=> rdata == ($past(req.wdata, 2) & 16'he0ff))
		else $error("clock control readback wrong");
	a_pad_edge_copy: assert property (w4 ##1 !req.wr [*2]
		|-> clock_pad_fast_edge == $past(req.wdata[13], 2))
		else $error("pad speed wrong");
	a_header_copy: assert property (w5 ##1 !req.wr [*2]
		|-> frame_cfg.header_word == $past(req.wdata, 2))
		else $error("header word wrong");
	a_addr_high_half: assert property (w6 ##1 !req.wr [*2]
		|-> frame_cfg.source_addr[31:16] == {$past(req.wdata[7:0], 2),
		$past(req.wdata[15:8], 2)}) else $error("address high half");
	a_addr_low_half: assert property (w7 ##1 !req.wr [*2]
		|-> frame_cfg.source_addr[15:0] == {$past(req.wdata[7:0], 2),
		$past(req.wdata[15:8], 2)}) else $error("address low half");
	a_out_disabled: assert property (w4 && !req.wdata[15]
		##1 !req.wr [*5] |-> !sync_clock_out) else $error("output not off");
	a_frame_hold: assert property (!req.wr [*2] |=> $stable(frame_cfg))
		else $error("frame fields moved");
endmodule
bind ptp_clkout_status_frame_cfg ptp_cfg_properties u_props (.clk(clk),
	.rstn(rstn), .req(req), .rdata(rdata), .sync_clock_out(sync_clock_out),
	.clock_pad_fast_edge(clock_pad_fast_edge), .frame_cfg(frame_cfg));
`default_nettype wire

/* verification/root_ticks.sv */
// root tick source: generator each cycle, oscillator every second
`timescale 1ns/1ps
`default_nettype none
module root_ticks (
	input  wire logic clk,
	output logic      pgm_tick,
	output logic      fco_tick
);
	// !== keeps the oscillator out of x before reset
	always @(posedge clk) begin
		pgm_tick <= 1'h1;
		fco_tick <= fco_tick !== 1'h1;
	end
endmodule
`default_nettype wire

/* verification/ptp_clkout_status_frame_cfg_tb.sv */
// self-checking bench for the page-6 bank
`timescale 1ns/1ps
`default_nettype none
`include "ptp_cfg_defines.svh"
module ptp_clkout_status_frame_cfg_tb;
	import ptp_cfg_pkg::*;
	logic              clk = 0, rstn = 0, pt, ft, so, pf;
	reg_req_s          req = '0;
	logic [15:0]       rd, d, v [4];
	status_frame_cfg_s fc;
	logic [31:0]       n;
	logic [7:0]        dv;
	int                err_total = 0, check_count = 0, i;
	root_ticks u_root (.clk(clk), .pgm_tick(pt), .fco_tick(ft));
	ptp_clkout_status_frame_cfg u_dut (.clk(clk), .rstn(rstn), .req(req),
		.pgm_tick(pt), .fco_tick(ft), .rdata(rd), .sync_clock_out(so),
		.clock_pad_fast_edge(pf), .frame_cfg(fc));
	initial forever #12.5 clk = ~clk;
	task chk(string s, logic [31:0] x, e);
		check_count++;
		if (x !== e) begin
			err_total++;
			$display("BAD %s exp %h seen %h", s, e, x);
		end
	endtask
	task wr(logic [2:0] p, logic [4:0] a, logic [15:0] x);
		req <= '{1'h1, p, a, x};
		@(posedge clk);
	endtask
	// read answers one edge after the address is taken
	task rdc(logic [2:0] p, logic [4:0] a, logic [15:0] e);
		req <= '{1'h0, p, a, 16'h0};
		repeat (2) @(posedge clk);
		#1 chk("rdata", rd, e);
	endtask
	task rises(int w, output logic [31:0] c);
		logic q;
		c = 0;
		q = so;
		repeat (w) begin
			@(posedge clk);
			c += (so === 1'h1 && q === 1'h0);
			q = so;
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		finish_test;
	end
	initial begin
		void'($urandom(16));
		repeat (16) @(posedge clk);
		rstn <= 1'h1;
		rdc(3'h6, `OFF_CLK_OUT_CTRL, `COC_RESET);
		for (i = 21; i < 24; i++) rdc(3'h6, i[4:0], 16'h0);
		// random words at every offset, read straight back
		repeat (12) for (i = 0; i < 4; i++) begin
			v[i] = 16'($urandom);
			wr(3'h6, 5'h14 + i[4:0], v[i]);
			d = i == 0 ? v[i] & `COC_RSVD_MASK : v[i];
			rdc(3'h6, 5'h14 + i[4:0], d);
		end
		chk("pad", pf, v[0][13]);
		chk("hdr", fc.header_word, v[1]);
		chk("sa", fc.source_addr, {v[2][7:0], v[2][15:8],
			v[3][7:0], v[3][15:8]});
		wr(3'h5, `OFF_HDR_WORD, ~v[1]);
		rdc(3'h5, `OFF_HDR_WORD, 16'h0);
		rdc(3'h6, `OFF_HDR_WORD, v[1]);
		rdc(3'h6, 5'h18, 16'h0);
		$display("register test done");
		// periods from both roots; the oscillator ticks half as often
		for (i = 0; i < 4; i++) begin
			dv = i < 2 ? 8'h2 : 8'(2 + $urandom % 30);
			d = {1'h1, i[0], 6'h0, dv};
			wr(3'h6, `OFF_CLK_OUT_CTRL, d);
			rdc(3'h6, `OFF_CLK_OUT_CTRL, d);
			repeat (600) @(posedge clk);
			rises(10 * dv * (i[0] ? 1 : 2), n);
			chk("rises", n, 32'ha);
		end
		// divider 0 and 1, then enable low: no edges at all
		for (i = 0; i < 3; i++) begin
			d = i == 2 ? 16'h400a : 16'hc000 | i[15:0];
			wr(3'h6, `OFF_CLK_OUT_CTRL, d);
			rdc(3'h6, `OFF_CLK_OUT_CTRL, d);
			repeat (600) @(posedge clk);
			rises(100, n);
			chk("stopped", n, 32'h0);
		end
		$display("clock test done");
		finish_test;
	end
endmodule
`default_nettype wire
